// ### bench/spf_peer.sv
// far side serial peripheral model that shifts words in and out on the shift clock
`timescale 1ns/1ns
module spf_peer (
   input  wire logic       i_arst_n,
   input  wire logic       i_sck,
   input  wire logic       i_sdo,
   input  wire logic       i_sel,
   input  wire logic [7:0] i_word,
   output logic            o_sck,
   output logic            o_sel_n,
   output logic            o_sdi,
   output logic [7:0]      o_rx,
   output logic [7:0]      o_sel_seen
);
   logic [2:0] bit_r;

   initial begin
      o_sck = 1'b1;
      o_sel_n = 1'b1;
      o_sdi = 1'b0;
   end

   // sample on the rising shift clock, whoever drives it
   always_ff @(posedge i_sck or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bit_r <= 3'h0;
      end else begin
         bit_r <= bit_r + 3'h1;
         o_rx <= {o_rx[6:0], i_sdo};
         o_sel_seen <= {o_sel_seen[6:0], i_sel};
      end
   end

   // launch on the falling edge, msb first
   always @(negedge i_sck) begin
      o_sdi <= i_word[3'h7 - bit_r];
   end

   // clock idles high and stands still between words; select is active low
   task automatic burst();
      o_sel_n = 1'b0;
      #3;
      repeat (8) begin
         o_sck = 1'b0;
         #3;
         o_sck = 1'b1;
         #3;
      end
      o_sel_n = 1'b1;
      // released data line must not keep showing the last bit
      o_sdi = ~o_sdi;
   endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the serial port pin front end
`timescale 1ns/1ns
module testbench;
   logic              i_clk;
   logic              i_arst_n;
   spf_pkg::spf_cfg_s i_cfg;
   logic              i_tx_valid;
   logic [7:0]        i_tx_data;
   logic              o_tx_ready;
   logic              o_rx_valid;
   logic [7:0]        o_rx_data;
   logic              i_rx_ready;
   logic              o_sck, o_sck_oe, o_sdo, o_sdo_oe, o_fr, o_fr_oe;
   logic              p_sck, p_sel_n, p_sdi;
   logic [7:0]        p_word, p_rx, p_sel_seen;
   wire               sck_w = o_sck_oe ? o_sck : p_sck;
   wire               sel_w = o_fr_oe ? o_fr : p_sel_n;
   wire               sdo_w = o_sdo_oe ? o_sdo : ~p_rx[0];
   int                errors;
   int                samples_checked;

   spf_front #(.WORD_W(8), .SCK_HALF(spf_pkg::SCK_HALF_CYC)) spf_front_i (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg(i_cfg),
      .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
      .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready),
      .i_shift_clock_line(sck_w), .o_shift_clock_line(o_sck),
      .o_shift_clock_line_oe(o_sck_oe), .i_serial_data_in_line(p_sdi),
      .o_serial_data_out_line(o_sdo), .o_serial_data_out_line_oe(o_sdo_oe),
      .i_select_low_line(sel_w), .o_frame_pulse_line(o_fr), .o_frame_pulse_line_oe(o_fr_oe));

   spf_peer spf_peer_i (
      .i_arst_n(i_arst_n), .i_sck(sck_w), .i_sdo(sdo_w), .i_sel(sel_w), .i_word(p_word),
      .o_sck(p_sck), .o_sel_n(p_sel_n), .o_sdi(p_sdi), .o_rx(p_rx), .o_sel_seen(p_sel_seen));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic test_done();
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic spf_pkg::spf_cfg_s mk(input spf_pkg::spf_pins_e pins,
                                            input logic m, input logic f, input logic b);
      mk.pins = pins;
      mk.master = m;
      mk.framed = f;
      mk.fifo_en = b;
   endfunction

   task automatic send(input logic [7:0] w);
      int k;
      k = 0;
      @(posedge i_clk);
      i_tx_valid <= 1'b1;
      i_tx_data <= w;
      do begin
         @(negedge i_clk);
         k++;
      end while (o_tx_ready !== 1'b1 && k < 200);
      @(posedge i_clk);
      i_tx_valid <= 1'b0;
   endtask

   task automatic get(input logic [7:0] exp);
      int k;
      k = 0;
      do begin
         @(negedge i_clk);
         k++;
      end while (o_rx_valid !== 1'b1 && k < 400);
      check(o_rx_valid === 1'b1 ? o_rx_data : ~exp, exp);
      @(posedge i_clk);
      i_rx_ready <= 1'b1;
      @(posedge i_clk);
      i_rx_ready <= 1'b0;
   endtask

   // the first master word only wakes the link side up, so it is drained unchecked
   task automatic do_reset(input spf_pkg::spf_cfg_s cfg);
      i_arst_n <= 1'b0;
      i_cfg <= cfg;
      repeat (16) @(posedge i_clk);
      check({o_sck_oe, o_sdo_oe, o_fr_oe, o_sck, o_tx_ready, o_rx_valid, 2'b00}, 8'h10);
      i_arst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      if (cfg.master) begin
         send(8'h00);
         i_rx_ready <= 1'b1;
         repeat (200) @(posedge i_clk);
         i_rx_ready <= 1'b0;
      end
   endtask

   task automatic master_xfer(input spf_pkg::spf_pins_e pins, input logic framed,
                              input logic [7:0] exp_sel);
      do_reset(mk(pins, 1'b1, framed, 1'b1));
      p_word <= 8'h3c;
      send(8'ha5);
      // the word reaches the shift side one burst late, so a zero burst comes first
      get(8'h3c);
      get(8'h3c);
      if (pins != spf_pkg::SPF_PINS_2) begin
         check(p_rx, 8'ha5);
      end
      if (pins == spf_pkg::SPF_PINS_4) begin
         check(p_sel_seen, exp_sel);
      end
      check({o_sck_oe, o_sdo_oe, o_fr_oe}, {1'b1, pins != spf_pkg::SPF_PINS_2,
            pins == spf_pkg::SPF_PINS_4});
   endtask

   task automatic fill(input int exp);
      int k;
      k = 0;
      @(posedge i_clk);
      i_tx_valid <= 1'b1;
      i_tx_data <= 8'h10;
      repeat (20) begin
         @(negedge i_clk);
         if (o_tx_ready === 1'b1) k++;
         @(posedge i_clk);
         i_tx_data <= 8'h10 + 8'(k);
      end
      i_tx_valid <= 1'b0;
      check(8'(k), 8'(exp));
   endtask

   // nine words arrive with the consumer stalled; only eight may be kept
   task automatic slave_buffers();
      int i;
      do_reset(mk(spf_pkg::SPF_PINS_4, 1'b0, 1'b0, 1'b1));
      fill(8);
      for (i = 0; i < 9; i++) begin
         p_word <= 8'hc0 + 8'(i);
         #20;
         spf_peer_i.burst();
         #20;
      end
      for (i = 0; i < 8; i++) begin
         get(8'hc0 + 8'(i));
      end
      repeat (8) @(posedge i_clk);
      check({7'h00, o_rx_valid}, 8'h00);
   endtask

   initial begin
      #400000;
      errors++;
      test_done();
   end

   initial begin
      errors = 0;
      samples_checked = 0;
      i_arst_n = 1'b0;
      i_cfg = spf_pkg::CFG_RST;
      i_tx_valid = 1'b0;
      i_tx_data = 8'h00;
      i_rx_ready = 1'b0;
      p_word = 8'h00;
      master_xfer(spf_pkg::SPF_PINS_4, 1'b0, 8'h00);
      master_xfer(spf_pkg::SPF_PINS_4, 1'b1, 8'h80);
      master_xfer(spf_pkg::SPF_PINS_3, 1'b0, 8'h00);
      master_xfer(spf_pkg::SPF_PINS_2, 1'b0, 8'h00);
      slave_buffers();
      do_reset(mk(spf_pkg::SPF_PINS_4, 1'b0, 1'b0, 1'b0));
      fill(1);
      test_done();
   end
endmodule

// ### hdl/spf_front.sv
// serial port pin front end: pin modes, clock generator, dual-clock word buffers
//
// Functional notes
// - Each direction holds eight words between shift logic and the word ports used by DMA: transmit in its buffer, receive seven buffered plus the output flop.
// - With buffering turned off the transmit direction holds at most a single word; receive holds one buffered word plus one on the output flop.
// - The port uses data in, data out, a driven or received shift clock and a select/frame line in 2, 3 or 4 pin modes.
// - The select line is active low as slave select and carries a frame pulse in framed operation.
// - In three-pin mode the select/frame line is neither driven nor sampled.
// - In two-pin mode only shift clock and data in are used; data out and select are left undriven.
`timescale 1ns/1ns

module spf_afifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          i_wclk,
   input  wire logic          i_arst_n,
   input  wire logic          i_wvalid,
   input  wire logic [W-1:0]  i_wdata,
   input  wire logic [AW:0]   i_wlim,
   output logic               o_wready,
   output logic [AW:0]        o_wfill,
   input  wire logic          i_rclk,
   input  wire logic          i_rready,
   output logic               o_rvalid,
   output logic [W-1:0]       o_rdata
);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wbin_r, wgray_r, rbin_r, rgray_r;
   logic [AW:0]  rq1_r, rq2_r, wq1_r, wq2_r;
   logic [AW:0]  wbin_nxt, rbin_nxt, wfill_nxt;
   logic         wpush, rpop;

   function automatic logic [AW:0] g2b(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   assign wpush     = i_wvalid & o_wready;
   assign wbin_nxt  = wbin_r + (AW+1)'(wpush);
   assign wfill_nxt = wbin_nxt - g2b(rq2_r);
   assign rpop      = i_rready & o_rvalid;
   assign rbin_nxt  = rbin_r + (AW+1)'(rpop);
   assign o_rdata   = mem[rbin_r[AW-1:0]];

   always_ff @(posedge i_wclk) begin
      if (wpush) begin
         mem[wbin_r[AW-1:0]] <= i_wdata;
      end
   end

   // ready is conservative: a stale read pointer only makes it late, never early
   always_ff @(posedge i_wclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wbin_r   <= '0;
         wgray_r  <= '0;
         rq1_r    <= '0;
         rq2_r    <= '0;
         o_wready <= 1'b0;
         o_wfill  <= '0;
      end else begin
         wbin_r   <= wbin_nxt;
         wgray_r  <= wbin_nxt ^ (wbin_nxt >> 1);
         rq1_r    <= rgray_r;
         rq2_r    <= rq1_r;
         o_wready <= wfill_nxt < i_wlim;
         o_wfill  <= wfill_nxt;
      end
   end

   always_ff @(posedge i_rclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rbin_r   <= '0;
         rgray_r  <= '0;
         wq1_r    <= '0;
         wq2_r    <= '0;
         o_rvalid <= 1'b0;
      end else begin
         rbin_r   <= rbin_nxt;
         rgray_r  <= rbin_nxt ^ (rbin_nxt >> 1);
         wq1_r    <= wgray_r;
         wq2_r    <= wq1_r;
         o_rvalid <= g2b(wq2_r) != rbin_nxt;
      end
   end
endmodule

module spf_front #(
   parameter int WORD_W   = 8,
   parameter int SCK_HALF = spf_pkg::SCK_HALF_CYC
) (
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire spf_pkg::spf_cfg_s i_cfg,
   input  wire logic              i_tx_valid,
   input  wire logic [WORD_W-1:0] i_tx_data,
   output logic                   o_tx_ready,
   output logic                   o_rx_valid,
   output logic [WORD_W-1:0]      o_rx_data,
   input  wire logic              i_rx_ready,
   input  wire logic              i_shift_clock_line,
   output logic                   o_shift_clock_line,
   output logic                   o_shift_clock_line_oe,
   input  wire logic              i_serial_data_in_line,
   output logic                   o_serial_data_out_line,
   output logic                   o_serial_data_out_line_oe,
   input  wire logic              i_select_low_line,
   output logic                   o_frame_pulse_line,
   output logic                   o_frame_pulse_line_oe
);
   localparam int AW  = $clog2(spf_pkg::FIFO_DEPTH);
   localparam int CW  = $clog2(WORD_W);
   localparam int GAP = spf_pkg::GAP_HALVES * SCK_HALF;
   localparam logic [AW:0] LIM_FULL = (AW+1)'(spf_pkg::FIFO_DEPTH);
   localparam logic [AW:0] LIM_ONE  = (AW+1)'(1);
   // the rx output flop holds one word, so the rx buffer keeps one fewer
   localparam logic [AW:0] LIM_RX   = (AW+1)'(spf_pkg::FIFO_DEPTH - 1);

   // ---------------- system clock side ----------------
   logic [AW:0]                   tx_fill;
   logic [AW:0]                   tx_lim, rx_lim;
   logic                          rxf_valid, rx_take;
   logic [WORD_W-1:0]             rxf_data;
   spf_pkg::spf_gen_e             gen_r;
   logic [spf_pkg::CNT_W-1:0]     half_r;
   logic [CW:0]                   edge_r;
   logic                          half_end, last_edge;

   // ---------------- link clock side ----------------
   logic                          sck_n;
   spf_pkg::spf_cfg_s             cfg1_r, cfg2_r;
   logic [CW-1:0]                 bit_cnt_r;
   logic [WORD_W-1:0]             rx_sh_r, tx_sh_r;
   logic                          word_tg_r, ld_tg_r;
   logic                          accept, last_bit, start;
   logic                          txf_valid;
   logic [WORD_W-1:0]             txf_data;

   // single-word mode narrows the buffers for DMA service
   assign tx_lim = i_cfg.fifo_en ? LIM_FULL : LIM_ONE;
   assign rx_lim = cfg2_r.fifo_en ? LIM_RX : LIM_ONE;

   spf_afifo #(.W(WORD_W), .DEPTH(spf_pkg::FIFO_DEPTH)) u_tx_fifo (
      .i_wclk   (i_clk),
      .i_arst_n (i_arst_n),
      .i_wvalid (i_tx_valid),
      .i_wdata  (i_tx_data),
      .i_wlim   (tx_lim),
      .o_wready (o_tx_ready),
      .o_wfill  (tx_fill),
      .i_rclk   (sck_n),
      .i_rready (start),
      .o_rvalid (txf_valid),
      .o_rdata  (txf_data)
   );

   spf_afifo #(.W(WORD_W), .DEPTH(spf_pkg::FIFO_DEPTH)) u_rx_fifo (
      .i_wclk   (i_shift_clock_line),
      .i_arst_n (i_arst_n),
      .i_wvalid (accept & last_bit),
      .i_wdata  ({rx_sh_r[WORD_W-2:0], i_serial_data_in_line}),
      .i_wlim   (rx_lim),
      .o_wready (),
      .o_wfill  (),
      .i_rclk   (i_clk),
      .i_rready (rx_take),
      .o_rvalid (rxf_valid),
      .o_rdata  (rxf_data)
   );

   // output stage keeps received words on flops
   assign rx_take = rxf_valid & (~o_rx_valid | i_rx_ready);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_valid <= 1'b0;
         o_rx_data  <= '0;
      end else if (rx_take) begin
         o_rx_valid <= 1'b1;
         o_rx_data  <= rxf_data;
      end else if (i_rx_ready) begin
         o_rx_valid <= 1'b0;
      end
   end

   // pin drive enables follow the configured pin mode and master setting; shift clock drive follows master only
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_shift_clock_line_oe     <= 1'b0;
         o_serial_data_out_line_oe <= 1'b0;
         o_frame_pulse_line_oe     <= 1'b0;
      end else begin
         o_shift_clock_line_oe     <= i_cfg.master;
         o_serial_data_out_line_oe <= i_cfg.pins != spf_pkg::SPF_PINS_2;
         o_frame_pulse_line_oe     <= i_cfg.master & (i_cfg.pins == spf_pkg::SPF_PINS_4);
      end
   end

   // master clock generator: idle high, one burst of WORD_W periods per word
   assign half_end  = half_r == spf_pkg::CNT_W'(SCK_HALF - 1);
   assign last_edge = edge_r == (CW+1)'(2 * WORD_W - 1);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         gen_r              <= spf_pkg::SPF_GEN_IDLE;
         half_r             <= '0;
         edge_r             <= '0;
         o_shift_clock_line <= 1'b1;
         o_frame_pulse_line <= 1'b1;
      end else begin
         unique case (gen_r)
            spf_pkg::SPF_GEN_IDLE: begin
               half_r             <= '0;
               edge_r             <= '0;
               o_frame_pulse_line <= ~i_cfg.framed;
               if (i_cfg.master && tx_fill != '0) begin
                  gen_r              <= spf_pkg::SPF_GEN_RUN;
                  o_shift_clock_line <= 1'b0;
                  o_frame_pulse_line <= i_cfg.framed;
               end
            end
            spf_pkg::SPF_GEN_RUN: begin
               half_r <= half_end ? '0 : half_r + 1'b1;
               if (half_end) begin
                  edge_r <= edge_r + 1'b1;
                  if (last_edge) begin
                     gen_r              <= spf_pkg::SPF_GEN_GAP;
                     o_frame_pulse_line <= ~i_cfg.framed;
                  end else begin
                     o_shift_clock_line <= ~o_shift_clock_line;
                  end
                  // the frame pulse covers bit 0 only
                  if (i_cfg.framed && edge_r == (CW+1)'(1)) begin
                     o_frame_pulse_line <= 1'b0;
                  end
               end
            end
            spf_pkg::SPF_GEN_GAP: begin
               // gap lets buffer pointers settle before the next burst
               half_r <= half_r + 1'b1;
               if (half_r == spf_pkg::CNT_W'(GAP - 1)) begin
                  gen_r <= spf_pkg::SPF_GEN_IDLE;
               end
            end
            default: begin
               gen_r <= spf_pkg::SPF_GEN_IDLE;
            end
         endcase
      end
   end

   // ---------------- link logic on the shift clock ----------------
   // data changes on falling edges, sampled on rising; the clock idles high
   assign sck_n    = ~i_shift_clock_line;
   assign last_bit = bit_cnt_r == CW'(WORD_W - 1);
   // three- and two-pin modes never look at the select line
   assign accept   = cfg2_r.master | (cfg2_r.pins != spf_pkg::SPF_PINS_4) |
                     (cfg2_r.framed ? (bit_cnt_r != '0) | i_select_low_line
                                    : ~i_select_low_line);
   assign start    = (bit_cnt_r == '0) & (ld_tg_r == word_tg_r);

   // config is static while the link runs; staging it on the system clock makes it
   // valid before the first burst, so the first master word is not misframed
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg1_r <= spf_pkg::CFG_RST;
         cfg2_r <= spf_pkg::CFG_RST;
      end else begin
         cfg1_r <= i_cfg;
         cfg2_r <= cfg1_r;
      end
   end

   always_ff @(posedge i_shift_clock_line or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bit_cnt_r <= '0;
         rx_sh_r   <= '0;
         word_tg_r <= 1'b0;
      end else if (accept) begin
         rx_sh_r <= {rx_sh_r[WORD_W-2:0], i_serial_data_in_line};
         if (last_bit) begin
            bit_cnt_r <= '0;
            word_tg_r <= ~word_tg_r;
         end else begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end
      end else if (!cfg2_r.framed) begin
         // select released mid-word drops the partial word
         bit_cnt_r <= '0;
      end
   end

   // an empty buffer at word start sends zeros
   always_ff @(negedge i_shift_clock_line or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ld_tg_r                <= 1'b0;
         tx_sh_r                <= '0;
         o_serial_data_out_line <= 1'b0;
      end else if (start) begin
         ld_tg_r                <= ~ld_tg_r;
         tx_sh_r                <= txf_valid ? {txf_data[WORD_W-2:0], 1'b0} : '0;
         o_serial_data_out_line <= txf_valid & txf_data[WORD_W-1];
      end else if (bit_cnt_r != '0) begin
         tx_sh_r                <= {tx_sh_r[WORD_W-2:0], 1'b0};
         o_serial_data_out_line <= tx_sh_r[WORD_W-1];
      end
   end

   chk_tx_depth_cap:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      tx_fill <= LIM_FULL)
      else $error("tx buffer holds more than its depth");

   chk_single_word:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (!i_cfg.fifo_en && tx_fill != '0) |-> !o_tx_ready)
      else $error("single-word mode accepted a second word");

   chk_clock_owner:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      $changed(i_cfg.master) |=> o_shift_clock_line_oe == $past(i_cfg.master))
      else $error("shift clock drive does not follow master mode");

   chk_burst_start:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (gen_r == spf_pkg::SPF_GEN_IDLE && i_cfg.master && tx_fill != '0)
      |=> (!o_shift_clock_line && gen_r == spf_pkg::SPF_GEN_RUN))
      else $error("master burst did not open with a falling edge");

   chk_idle_high:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (gen_r == spf_pkg::SPF_GEN_GAP) |-> o_shift_clock_line)
      else $error("shift clock not high between bursts");

   chk_select_low:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (gen_r == spf_pkg::SPF_GEN_RUN && !i_cfg.framed && $stable(i_cfg.framed))
      |-> !o_frame_pulse_line)
      else $error("select not low during a master word");

   chk_frame_pulse:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (gen_r == spf_pkg::SPF_GEN_RUN && i_cfg.framed && $stable(i_cfg.framed))
      |-> o_frame_pulse_line == (edge_r < (CW+1)'(2)))
      else $error("frame pulse not confined to bit 0");

   chk_three_pin_quiet:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_cfg.pins == spf_pkg::SPF_PINS_3) |=> !o_frame_pulse_line_oe)
      else $error("select line driven in three-pin mode");

   chk_two_pin_quiet:
   assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_cfg.pins == spf_pkg::SPF_PINS_2) |=>
      (!o_serial_data_out_line_oe && !o_frame_pulse_line_oe))
      else $error("data out or select driven in two-pin mode");
endmodule

// ### hdl/spf_pkg.sv
// shared constants and types for the serial port pin front end
package spf_pkg;
   localparam int FIFO_DEPTH    = 8;
   localparam int SYS_PERIOD_NS = 10;
   localparam int SCK_PERIOD_NS = 80;
   localparam int SCK_HALF_CYC  = (SCK_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int GAP_HALVES    = 2;
   localparam int CNT_W         = 16;

   typedef enum logic [1:0] {
      SPF_PINS_2 = 2'b00,
      SPF_PINS_3 = 2'b01,
      SPF_PINS_4 = 2'b10
   } spf_pins_e;

   typedef enum logic [1:0] {
      SPF_GEN_IDLE = 2'b00,
      SPF_GEN_RUN  = 2'b01,
      SPF_GEN_GAP  = 2'b10
   } spf_gen_e;

   typedef struct packed {
      spf_pins_e pins;
      logic      master;
      logic      framed;
      logic      fifo_en;
   } spf_cfg_s;

   localparam spf_cfg_s CFG_RST = '{pins: SPF_PINS_4, master: 1'b0, framed: 1'b0,
                                    fifo_en: 1'b1};
endpackage
